// *** pkg/adc_seq_pkg.sv ***
`default_nettype none
package adc_seq_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] COMM_ADDR = 8'h00;
    localparam logic [7:0] SETUP_ADDR = 8'h04;
    localparam logic [7:0] CLOCK_ADDR = 8'h08;
    localparam logic [7:0] DATA_ADDR = 8'h0C;
    localparam logic [7:0] OFFS0_ADDR = 8'h10;
    localparam logic [7:0] GAIN0_ADDR = 8'h14;
    localparam logic [7:0] OFFS1_ADDR = 8'h18;
    localparam logic [7:0] GAIN1_ADDR = 8'h1C;

    // ----------------------------------------
    // Field layouts
    // ----------------------------------------
    typedef struct packed {
        logic result_ready_n;
        logic [4:0] rsvd;
        logic chan;
        logic power_down_bit;
    } comm_reg_s;

    typedef struct packed {
        logic buffer_on;
        logic bipolar;
        logic [2:0] gain;
        logic filter_sync_hold;
        logic calib_mode_hi;
        logic calib_mode_lo;
    } setup_reg_s;

    typedef struct packed {
        logic [1:0] rsvd;
        logic internal_osc;
        logic clock_output_disable;
        logic clock_select;
        logic clock_halving_bit;
        logic filter_select_hi;
        logic filter_select_lo;
    } clock_reg_s;

    localparam logic [7:0] COMM_RST = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h04;
    localparam logic [7:0] CLOCK_RST = 8'h00;
    localparam logic [15:0] COEF_RST = 16'h0000;

    // ----------------------------------------
    // Modes and timing
    // ----------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SELF = 2'h1;
    localparam logic [1:0] MODE_SYS_ZERO = 2'h2;
    localparam logic [1:0] MODE_SYS_FULL = 2'h3;

    localparam logic [3:0] CAL_PERIODS = 4'h3;
    localparam logic [3:0] FIRST_CONV_PERIODS = 4'h3;
    localparam logic [3:0] SYS_CONV_PERIODS = 4'h1;
    localparam logic [3:0] RUN_PERIODS = 4'h1;

    localparam int MODULATOR_CLOCKS_DEF = 128;
    localparam int PIPELINE_CLOCKS_DEF = 2000;

    localparam logic [8:0] DEC_391 = 9'h187;
    localparam logic [8:0] DEC_313 = 9'h139;
    localparam logic [8:0] DEC_78 = 9'h04E;
    localparam logic [8:0] DEC_39 = 9'h027;
    localparam logic [8:0] DEC_384 = 9'h180;
    localparam logic [8:0] DEC_320 = 9'h140;
    localparam logic [8:0] DEC_77 = 9'h04D;
    localparam logic [8:0] DEC_38 = 9'h026;

    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_CAL_ZERO = 6'h02,
        PH_CAL_FULL = 6'h04,
        PH_PIPE = 6'h08,
        PH_CONVERT = 6'h10,
        PH_RUN = 6'h20
    } phase_e;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

    typedef struct packed {
        logic short_inputs;
        logic apply_ref;
        logic mod_reset;
        logic osc_enable;
        logic clock_output_pin_enable;
        logic powered_down;
    } afe_ctl_s;

endpackage
`default_nettype wire

// *** logic/adc_calibration_powerdown_seq.sv ***
// Operation
// - Mode 01 with hold low runs self-calibration six periods, then clears mode
// - Self-calibration measures shorted-input zero first, then internal reference full scale
// - After self-calibration a normal conversion completes within three periods
// - Result-ready rises at start, falls nine periods later with valid result
// - If result-ready is low at command, rising may wait one modulator cycle
// - Mode 10 with hold low runs zero-scale system calibration, mode clears after three
// - Zero-scale system calibration: result-ready falls after four periods
// - Mode 11 runs full-scale system calibration, mode clears after three periods
// - Full-scale system calibration: result-ready falls after four periods with new data
// - Bipolar coefficients use midpoint and positive full scale; unipolar uses endpoints
// - Power-down bit enters power-down leaving bus and result-ready untouched
// - All registers keep their contents while powered down
// - Result-ready high at power-down stays high until a new result
// - Result-ready low at power-down: data stays readable, a read raises it
// - Leaving power-down: first result after pipeline delay plus three periods
// - Crystal source with clock output enabled keeps clock output running
// - Internal oscillator stops while powered down
// - Filter-sync hold high resets filter and modulator; nothing proceeds
// - Period is modulator clocks times decimation, doubled by halving bit
// - Result-ready returns high after a data register read completes
// - Coefficients go to the offset and gain pair of the selected channel
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_powerdown_seq #(
    parameter int MODULATOR_CLOCKS = adc_seq_pkg::MODULATOR_CLOCKS_DEF,
    parameter int PIPELINE_CLOCKS = adc_seq_pkg::PIPELINE_CLOCKS_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire adc_seq_pkg::wb_req_s wb_req,
    output adc_seq_pkg::wb_rsp_s wb_rsp,
    input wire logic [15:0] conv_sample,
    output logic result_ready_n,
    output adc_seq_pkg::afe_ctl_s afe
);
    import adc_seq_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        phase_e phase;
        logic [17:0] clk_cnt;
        logic [7:0] mod_cnt;
        logic [3:0] per_cnt;
        logic [3:0] target;
        logic [10:0] pipe_cnt;
        comm_reg_s comm;
        setup_reg_s setup;
        clock_reg_s clkreg;
        logic hold_q;
        logic start_cmd;
        logic raise_pend;
        logic result_ready_n_n;
        logic [15:0] data;
        logic [15:0] zero_meas;
        logic [1:0][15:0] offs;
        logic [1:0][15:0] gain;
        logic ack;
        logic [31:0] rdat;
        afe_ctl_s afe;
    } state_s;

    state_s s;
    state_s next_s;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [17:0] period_clocks(input clock_reg_s c);
        logic [8:0] dec;
        logic [17:0] p;
        case ({c.clock_select, c.filter_select_hi, c.filter_select_lo})
            3'h0: dec = DEC_391;
            3'h1: dec = DEC_313;
            3'h2: dec = DEC_78;
            3'h3: dec = DEC_39;
            3'h4: dec = DEC_384;
            3'h5: dec = DEC_320;
            3'h6: dec = DEC_77;
            default: dec = DEC_38;
        endcase
        p = 18'(MODULATOR_CLOCKS) * 18'(dec);
        return c.clock_halving_bit ? 18'(p << 1) : p;
    endfunction

    // Bipolar zero is midscale, so the span seen is only half the range
    function automatic logic [15:0] gain_coef(input logic [15:0] full, input logic [15:0] zero,
                                              input logic bip);
        logic [15:0] span;
        span = 16'(full - zero);
        return bip ? 16'(span << 1) : span;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    logic [17:0] per_len;
    logic period_end;
    logic last_period;
    logic req;
    logic acc;
    logic [1:0] mode;

    assign per_len = period_clocks(s.clkreg);
    assign period_end = (s.clk_cnt == 18'(per_len - 18'h00001));
    assign last_period = period_end && (s.per_cnt == 4'(s.target - 4'h1));
    assign req = wb_req.cyc & wb_req.stb;
    assign acc = req & s.ack;
    assign mode = {s.setup.calib_mode_hi, s.setup.calib_mode_lo};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.ack = req & ~s.ack;
        next_s.hold_q = s.setup.filter_sync_hold;
        next_s.start_cmd = 1'b0;
        next_s.mod_cnt = (s.mod_cnt == 8'(MODULATOR_CLOCKS - 1)) ? 8'h00 : 8'(s.mod_cnt + 8'h01);

        // Read data is presented together with ack
        if (req & ~s.ack & ~wb_req.we) begin
            case (wb_req.adr)
                COMM_ADDR: next_s.rdat = {24'h000000, s.comm.rsvd == 5'h00 ? 1'b0 : 1'b0,
                                          7'h00} | 32'({s.result_ready_n_n, 5'h00, s.comm.chan,
                                          s.comm.power_down_bit});
                SETUP_ADDR: next_s.rdat = 32'(s.setup);
                CLOCK_ADDR: next_s.rdat = 32'({2'h0, s.clkreg[5:0]});
                DATA_ADDR: next_s.rdat = 32'(s.data);
                OFFS0_ADDR: next_s.rdat = 32'(s.offs[0]);
                GAIN0_ADDR: next_s.rdat = 32'(s.gain[0]);
                OFFS1_ADDR: next_s.rdat = 32'(s.offs[1]);
                GAIN1_ADDR: next_s.rdat = 32'(s.gain[1]);
                default: next_s.rdat = 32'h00000000;
            endcase
        end

        // A read clears first so that a result in the same cycle wins
        if (acc & ~wb_req.we & (wb_req.adr == DATA_ADDR)) begin
            next_s.result_ready_n_n = 1'b1;
        end

        if (s.raise_pend && (s.mod_cnt == 8'(MODULATOR_CLOCKS - 1))) begin
            next_s.result_ready_n_n = 1'b1;
            next_s.raise_pend = 1'b0;
        end

        // ----------------------------------------
        // Sequencer
        // ----------------------------------------
        if (s.setup.filter_sync_hold) begin
            next_s.phase = PH_IDLE;
            next_s.clk_cnt = 18'h00000;
            next_s.per_cnt = 4'h0;
        end else if (s.comm.power_down_bit) begin
            next_s.phase = s.phase;
        end else if ((s.hold_q & ~s.setup.filter_sync_hold) | s.start_cmd) begin
            next_s.clk_cnt = 18'h00000;
            next_s.per_cnt = 4'h0;
            next_s.target = CAL_PERIODS;
            case (mode)
                MODE_SELF: next_s.phase = PH_CAL_ZERO;
                MODE_SYS_ZERO: next_s.phase = PH_CAL_ZERO;
                MODE_SYS_FULL: next_s.phase = PH_CAL_FULL;
                default: begin
                    next_s.phase = PH_CONVERT;
                    next_s.target = FIRST_CONV_PERIODS;
                end
            endcase
            // A read in this same cycle may already have raised result-ready
            if (mode != MODE_NORMAL) begin
                if (~next_s.result_ready_n_n) begin
                    next_s.raise_pend = 1'b1;
                end
            end
        end else begin
            next_s.clk_cnt = period_end ? 18'h00000 : 18'(s.clk_cnt + 18'h00001);
            if (period_end) begin
                next_s.per_cnt = last_period ? 4'h0 : 4'(s.per_cnt + 4'h1);
            end
            case (s.phase)
                PH_CAL_ZERO: begin
                    if (last_period) begin
                        if (mode == MODE_SELF) begin
                            next_s.zero_meas = conv_sample;
                            next_s.phase = PH_CAL_FULL;
                            next_s.target = CAL_PERIODS;
                        end else begin
                            next_s.offs[s.comm.chan] = conv_sample;
                            next_s.setup.calib_mode_hi = 1'b0;
                            next_s.setup.calib_mode_lo = 1'b0;
                            next_s.phase = PH_CONVERT;
                            next_s.target = SYS_CONV_PERIODS;
                        end
                    end
                end
                PH_CAL_FULL: begin
                    if (last_period) begin
                        if (mode == MODE_SELF) begin
                            next_s.offs[s.comm.chan] = s.zero_meas;
                            next_s.gain[s.comm.chan] = gain_coef(conv_sample, s.zero_meas,
                                                                 s.setup.bipolar);
                            next_s.target = FIRST_CONV_PERIODS;
                        end else begin
                            next_s.gain[s.comm.chan] = gain_coef(conv_sample,
                                                                 s.offs[s.comm.chan],
                                                                 s.setup.bipolar);
                            next_s.target = SYS_CONV_PERIODS;
                        end
                        next_s.setup.calib_mode_hi = 1'b0;
                        next_s.setup.calib_mode_lo = 1'b0;
                        next_s.phase = PH_CONVERT;
                    end
                end
                PH_PIPE: begin
                    next_s.clk_cnt = 18'h00000;
                    next_s.per_cnt = 4'h0;
                    if (s.pipe_cnt == 11'(PIPELINE_CLOCKS - 1)) begin
                        next_s.phase = PH_CONVERT;
                        next_s.target = FIRST_CONV_PERIODS;
                    end else begin
                        next_s.pipe_cnt = 11'(s.pipe_cnt + 11'h001);
                    end
                end
                PH_CONVERT, PH_RUN: begin
                    if (last_period) begin
                        next_s.data = conv_sample;
                        next_s.result_ready_n_n = 1'b0;
                        next_s.raise_pend = 1'b0;
                        next_s.phase = PH_RUN;
                        next_s.target = RUN_PERIODS;
                    end
                end
                default: next_s.phase = PH_IDLE;
            endcase
        end

        // ----------------------------------------
        // Register writes, taken at the ack edge
        // ----------------------------------------
        if (acc & wb_req.we & wb_req.sel[0]) begin
            case (wb_req.adr)
                COMM_ADDR: begin
                    if (s.comm.power_down_bit & ~wb_req.dat[0]) begin
                        next_s.phase = PH_PIPE;
                        next_s.pipe_cnt = 11'h000;
                    end
                    next_s.comm.power_down_bit = wb_req.dat[0];
                    next_s.comm.chan = wb_req.dat[1];
                end
                SETUP_ADDR: begin
                    next_s.setup = setup_reg_s'(wb_req.dat[7:0]);
                    next_s.start_cmd = ~wb_req.dat[2] & (wb_req.dat[1:0] != MODE_NORMAL);
                end
                CLOCK_ADDR: next_s.clkreg = clock_reg_s'({2'h0, wb_req.dat[5:0]});
                default: next_s.clkreg = next_s.clkreg;
            endcase
        end
        if (acc & wb_req.we) begin
            case (wb_req.adr)
                OFFS0_ADDR: next_s.offs[0] = merge16(s.offs[0], wb_req.dat, wb_req.sel);
                GAIN0_ADDR: next_s.gain[0] = merge16(s.gain[0], wb_req.dat, wb_req.sel);
                OFFS1_ADDR: next_s.offs[1] = merge16(s.offs[1], wb_req.dat, wb_req.sel);
                GAIN1_ADDR: next_s.gain[1] = merge16(s.gain[1], wb_req.dat, wb_req.sel);
                default: next_s.data = next_s.data;
            endcase
        end

        // ----------------------------------------
        // Front-end controls
        // ----------------------------------------
        next_s.afe.short_inputs = (s.phase == PH_CAL_ZERO) && (mode == MODE_SELF);
        next_s.afe.apply_ref = (s.phase == PH_CAL_FULL) && (mode == MODE_SELF);
        next_s.afe.mod_reset = s.setup.filter_sync_hold;
        // Power-down gates the oscillator and clock output pin only with the internal oscillator; every register keeps its value
        next_s.afe.osc_enable = ~(s.comm.power_down_bit & s.clkreg.internal_osc);
        next_s.afe.clock_output_pin_enable = ~s.clkreg.clock_output_disable &
                                   ~(s.comm.power_down_bit & s.clkreg.internal_osc);
        next_s.afe.powered_down = s.comm.power_down_bit;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.phase <= PH_IDLE;
            s.comm <= comm_reg_s'(COMM_RST);
            s.setup <= setup_reg_s'(SETUP_RST);
            s.clkreg <= clock_reg_s'(CLOCK_RST);
            s.hold_q <= 1'b1;
            s.result_ready_n_n <= 1'b1;
            s.target <= FIRST_CONV_PERIODS;
            s.offs <= {COEF_RST, COEF_RST};
            s.gain <= {COEF_RST, COEF_RST};
            s.afe <= '{mod_reset: 1'b1, osc_enable: 1'b1, clock_output_pin_enable: 1'b1, default: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp.ack = s.ack;
    assign wb_rsp.dat = s.rdat;
    assign result_ready_n = s.result_ready_n_n;
    assign afe = s.afe;

endmodule // adc_calibration_powerdown_seq
`default_nettype wire

// *** dv/adc_seq_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk #(
    parameter int MODULATOR_CLOCKS = 128,
    parameter int PIPELINE_CLOCKS = 2000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire adc_seq_pkg::wb_req_s wb_req,
    input wire adc_seq_pkg::wb_rsp_s wb_rsp,
    input wire logic result_ready_n,
    input wire adc_seq_pkg::afe_ctl_s afe
);
    import adc_seq_pkg::*;
    // ----
    // Bus and sequencer relations
    // ----
    // A pending result may hold ready low for one modulator cycle, hence the margin
    localparam int RISE_MAX = MODULATOR_CLOCKS + 4;
    wire logic req = wb_req.cyc && wb_req.stb;
    wire logic data_rd = wb_rsp.ack && !wb_req.we && wb_req.adr == DATA_ADDR;
    wire logic cal_wr = wb_rsp.ack && wb_req.we && wb_req.adr == SETUP_ADDR
        && !wb_req.dat[2] && wb_req.dat[1:0] != 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ack_next_a: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("bus request not acknowledged in one cycle");
    ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("acknowledge longer than one cycle");
    cal_raise_a: assert property (cal_wr |-> ##[1:RISE_MAX] result_ready_n)
        else $error("result ready not raised at calibration start");
    zero_first_a: assert property ($rose(afe.apply_ref) |-> $past(afe.short_inputs))
        else $error("full scale not preceded by zero scale");
    hold_freeze_a: assert property (afe.mod_reset && result_ready_n |=> result_ready_n)
        else $error("result produced while filter held");
    pd_high_a: assert property (afe.powered_down && result_ready_n |=> result_ready_n)
        else $error("result produced while powered down");
    pd_low_a: assert property (
        afe.powered_down && !result_ready_n && !wb_rsp.ack |=> !result_ready_n)
        else $error("result ready changed in power-down without a read");
    read_release_a: assert property (data_rd |=> result_ready_n)
        else $error("result ready not released by data read");
    osc_stop_a: assert property (!afe.osc_enable |-> afe.powered_down)
        else $error("oscillator stopped outside power-down");
endmodule // adc_seq_chk

bind adc_calibration_powerdown_seq adc_seq_chk #(
    .MODULATOR_CLOCKS(MODULATOR_CLOCKS), .PIPELINE_CLOCKS(PIPELINE_CLOCKS)
) u_chk (
    .clk(clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .result_ready_n(result_ready_n), .afe(afe)
);
`default_nettype wire

// *** dv/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clk,
    output adc_seq_pkg::wb_req_s wb_req,
    input wire adc_seq_pkg::wb_rsp_s wb_rsp
);
    import adc_seq_pkg::*;
    int hung = 0;
    initial wb_req = '0;
    // One classic cycle; released lines show inverted data, never the stale word
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
        output logic [31:0] rdat);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wdat};
        @(posedge clk);
        while (wb_rsp.ack !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        if (n == 16) hung++;
        rdat = wb_rsp.dat;
        wb_req <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, adr: ~adr, sel: 4'h0, dat: ~wdat};
        @(posedge clk);
    endtask
endmodule // host_bus_model
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("MISMATCH %s expected %0h seen %0h", w, e, g); \
        end \
    end
module tb;
    import adc_seq_pkg::*;
    localparam int MC = 2;
    localparam int PC = 10;
    localparam int P = MC * 38;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] conv_sample = 16'hA5C3;
    wb_req_s wb_req;
    wb_rsp_s wb_rsp;
    logic result_ready_n;
    afe_ctl_s afe;
    int err_count = 0;
    int comparisons = 0;
    int tick = 0;
    logic [31:0] rdat;

    initial forever #50 clk = ~clk;
    always @(posedge clk) tick <= tick + 1;
    // Inputs read as 16'h0123 while shorted and as 16'h4567 while the reference is applied
    always @(posedge clk) conv_sample <= afe.short_inputs ? 16'h0123 :
        (afe.apply_ref ? 16'h4567 : 16'hA5C3);

    adc_calibration_powerdown_seq #(.MODULATOR_CLOCKS(MC), .PIPELINE_CLOCKS(PC)) uut (
        .clk(clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .conv_sample(conv_sample), .result_ready_n(result_ready_n), .afe(afe)
    );
    host_bus_model host (.clk(clk), .wb_req(wb_req), .wb_rsp(wb_rsp));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d);
        host.xfer(we, a, {16'h0, d}, rdat);
        if (host.hung != 0) begin
            err_count++;
            print_verdict();
        end
    endtask
    task automatic rd(input string w, input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0);
        `CHK(w, e, rdat[15:0])
    endtask
    task automatic until_cyc(input int c);
        while (tick < c) @(posedge clk);
    endtask
    task automatic wait_result_ready_n(input logic v, input int bound);
        int n;
        n = 0;
        while (result_ready_n !== v && n < bound) begin
            @(posedge clk);
            n++;
        end
        `CHK("ready wait", v, result_ready_n)
        if (result_ready_n !== v) print_verdict();
    endtask
    // Mode bits are polled just before and just after their expected clear point
    task automatic run_cal(input logic [7:0] setup, input int m, input int n);
        int t0;
        t0 = tick;
        bus(1'b1, SETUP_ADDR, {8'h0, setup});
        wait_result_ready_n(1'b1, MC + 4);
        until_cyc(t0 + P);
        `CHK("shorted", setup[1:0] == 2'h1, afe.short_inputs)
        until_cyc(t0 + m * P - 10);
        `CHK("reference", setup[1:0] == 2'h1, afe.apply_ref)
        rd("mode busy", SETUP_ADDR, {8'h0, setup});
        until_cyc(t0 + m * P + 8);
        rd("mode clear", SETUP_ADDR, {8'h0, setup & 8'hFC});
        wait_result_ready_n(1'b0, n * P);
        `CHK("cal delay", 1'b1, tick - t0 >= n * P && tick - t0 <= n * P + 8)
    endtask

    initial begin
        int t0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK("hold at reset", 1'b1, afe.mod_reset)
        `CHK("pd at reset", 1'b0, afe.powered_down)
        `CHK("ref at reset", 1'b0, afe.apply_ref)
        `CHK("osc at reset", 1'b1, afe.osc_enable)
        rd("comm", COMM_ADDR, 16'h0080);
        rd("setup", SETUP_ADDR, 16'h0004);
        rd("clock", CLOCK_ADDR, 16'h0000);
        bus(1'b1, 8'h20, 16'h00FF);
        rd("unmapped", 8'h20, 16'h0000);
        bus(1'b1, CLOCK_ADDR, 16'h000B);
        run_cal(8'h02, 3, 4);
        run_cal(8'h03, 3, 4);
        run_cal(8'h01, 6, 9);
        rd("result", DATA_ADDR, 16'hA5C3);
        `CHK("read release", 1'b1, result_ready_n)
        rd("offset ch0", OFFS0_ADDR, 16'h0123);
        rd("gain ch0", GAIN0_ADDR, 16'h4444);
        bus(1'b1, COMM_ADDR, 16'h0002);
        run_cal(8'h41, 6, 9);
        rd("offset ch1", OFFS1_ADDR, 16'h0123);
        rd("gain ch1", GAIN1_ADDR, 16'h8888);
        bus(1'b1, SETUP_ADDR, 16'h0004);
        bus(1'b0, DATA_ADDR, 16'h0000);
        until_cyc(tick + 3 * P);
        `CHK("held", 1'b1, result_ready_n)
        t0 = tick;
        bus(1'b1, SETUP_ADDR, 16'h0000);
        wait_result_ready_n(1'b0, 3 * P + 8);
        `CHK("first result", 1'b1, tick - t0 >= 3 * P)
        bus(1'b0, DATA_ADDR, 16'h0000);
        bus(1'b1, COMM_ADDR, 16'h0001);
        @(posedge clk);
        `CHK("powered down", 1'b1, afe.powered_down)
        `CHK("clock out", 1'b1, afe.clock_output_pin_enable)
        until_cyc(tick + 2 * P);
        `CHK("high in pd", 1'b1, result_ready_n)
        bus(1'b1, CLOCK_ADDR, 16'h002B);
        @(posedge clk);
        `CHK("osc off", 1'b0, afe.osc_enable)
        rd("setup kept", SETUP_ADDR, 16'h0000);
        rd("gain kept", GAIN1_ADDR, 16'h8888);
        until_cyc(tick + 50);
        t0 = tick;
        bus(1'b1, COMM_ADDR, 16'h0000);
        wait_result_ready_n(1'b0, PC + 3 * P + 10);
        `CHK("wake delay", 1'b1, tick - t0 >= PC + 3 * P && tick - t0 <= PC + 3 * P + 8)
        bus(1'b1, COMM_ADDR, 16'h0001);
        until_cyc(tick + 2 * P);
        `CHK("low in pd", 1'b0, result_ready_n)
        rd("data in pd", DATA_ADDR, 16'hA5C3);
        `CHK("pd release", 1'b1, result_ready_n)
        bus(1'b1, COMM_ADDR, 16'h0000);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
